// *** rtl/tws_pkg.sv ***
// What this block does
// R1: data changes only while clock low; a change while clock high is start or stop
// R2: start is data falling with clock high; nothing is answered before one
// R3: stop is data rising with clock high; master ends every operation with it
// R4: receiver of each byte pulls data low in the following clock pulse
// R5: master recovers a stuck bus with up to nine clocks then a start
// R6: standby after power-up, after stop of a non-write, after a write cycle
// R7: answer only when the top four address bits equal the device-type code
// R8: three block-select bits pick one of eight 256-byte blocks
// R9: address bit zero set means read, clear means write
// R10: a matching address byte is acknowledged on the ninth clock
// R11: byte write is address, word address, data, each acknowledged, then stop
// R12: no answer to the master while an internal write is running
// R13: page write takes up to 16 data bytes, each acknowledged at once
// R14: only the low four address bits step after each write byte, wrapping in page
// R15: beyond 16 bytes the page pointer wraps and later bytes replace earlier
// R16: stop after a page write commits all buffered bytes in one cycle
// R17: polling gets no acknowledge while busy and one once the write is done
// R18: address counter holds last address plus one and wraps to zero
// R19: master ends a single read with no acknowledge and a stop
// R20: random read is a dummy write, repeated start, read address byte
// R21: sequential read sends the next byte on every master acknowledge
// R22: sequential read wraps from the top of the array to zero without a gap
// R23: write-protect input high makes the whole array read-only
// R24: internal write cycle ends within 5 ms of its stop
// R25: array is 2048 bytes of eight bits, counter eleven bits
// R26: counter is block-select bits above the received word address byte
package tws_pkg;
   localparam int ADDR_W = 11;
   localparam int MEM_BYTES = 2048;
   localparam int PAGE_BYTES = 16;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h9;
   localparam logic [3:0] PAGE_TOP = 4'hf;
   localparam int T_WR_MS = 5;
   localparam int CLK_SYS_HZ = 20000000;
   // cycles left free for the crossing and the array commit inside the limit
   localparam int WR_SLACK = 1000;
   localparam int WR_CYC = T_WR_MS * (CLK_SYS_HZ / 1000) - WR_SLACK;
   localparam int WR_CNT_W = 17;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEV = 3'h1,
      ST_WORD = 3'h2,
      ST_WDATA = 3'h3,
      ST_RDATA = 3'h4
   } tws_state_t;
endpackage : tws_pkg

// *** rtl/tws_eeprom.sv ***
module tws_eeprom #(
   parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary value
   parameter int WR_CYC = tws_pkg::WR_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic clk_link,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic wp_i,
   output logic standby,
   output logic wr_busy
);

   typedef struct packed {
      tws_pkg::tws_state_t st;
      logic [3:0] cnt;
      logic ackph;
      logic [7:0] sh;
      logic [2:0] blk;
      logic [10:0] addr;
      logic [15:0] mask;
      logic [6:0] cpage;
      logic busy;
      logic cm_on;
      logic [3:0] cm_idx;
      logic req_t;
      logic dn_s1;
      logic dn_s2;
      logic dn_p;
      logic oe;
      logic stby;
      logic wp_s1;
      logic wp_s2;
      logic scl_s1;
      logic scl_s2;
      logic scl_p;
      logic sda_s1;
      logic sda_s2;
      logic sda_p;
   } tws_link_t;

   typedef struct packed {
      logic rq_s1;
      logic rq_s2;
      logic rq_p;
      logic run;
      logic [16:0] cnt;
      logic dn_t;
   } tws_sys_t;

   tws_link_t l_r;
   tws_link_t l_nxt;
   tws_sys_t s_r;
   tws_sys_t s_nxt;
   logic lrst_a;
   logic lrst_b;

   logic [7:0] mem [tws_pkg::MEM_BYTES]; // R25
   logic [7:0] pbuf [tws_pkg::PAGE_BYTES];
   logic mem_we;
   logic [10:0] mem_wa;
   logic [7:0] mem_wd;
   logic pb_we;
   logic [7:0] mem_rd;

   logic scl_h;
   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;
   logic byte_end;
   logic dev_end;
   logic wd_end;
   logic rd_load;
   logic dn_ev;
   logic cm_last;
   logic dev_match;

   // reset into the link domain
   always_ff @(posedge clk_link) begin
      lrst_a <= rst;
      lrst_b <= lrst_a;
   end

   assign scl_h = l_r.scl_s2 & l_r.scl_p;
   assign start_ev = scl_h & l_r.sda_p & ~l_r.sda_s2; // R1 R2
   assign stop_ev = scl_h & ~l_r.sda_p & l_r.sda_s2; // R1 R3
   assign rise_ev = l_r.scl_s2 & ~l_r.scl_p;
   assign fall_ev = ~l_r.scl_s2 & l_r.scl_p;
   assign byte_end = fall_ev && l_r.cnt == tws_pkg::BIT_LAST && !l_r.ackph;
   assign dev_end = byte_end && l_r.st == tws_pkg::ST_DEV;
   assign wd_end = byte_end && l_r.st == tws_pkg::ST_WDATA;
   assign rd_load = fall_ev && l_r.st == tws_pkg::ST_RDATA && l_r.ackph;
   assign dev_match = l_r.sh[7:4] == DEV_CODE;
   assign dn_ev = l_r.dn_s2 != l_r.dn_p;
   assign cm_last = l_r.cm_on && !dn_ev && l_r.cm_idx == tws_pkg::PAGE_TOP;
   assign mem_rd = mem[l_r.addr];

   always_comb begin
      l_nxt = l_r;
      mem_we = 1'b0;
      mem_wa = {l_r.cpage, l_r.cm_idx};
      mem_wd = pbuf[l_r.cm_idx];
      pb_we = 1'b0;
      l_nxt.scl_s1 = scl_i;
      l_nxt.scl_s2 = l_r.scl_s1;
      l_nxt.scl_p = l_r.scl_s2;
      l_nxt.sda_s1 = sda_i;
      l_nxt.sda_s2 = l_r.sda_s1;
      l_nxt.sda_p = l_r.sda_s2;
      l_nxt.wp_s1 = wp_i;
      l_nxt.wp_s2 = l_r.wp_s1;
      l_nxt.dn_s1 = s_r.dn_t;
      l_nxt.dn_s2 = l_r.dn_s1;
      l_nxt.dn_p = l_r.dn_s2;

      // copy the page buffer into the array after the timed cycle
      if (dn_ev) begin
         l_nxt.cm_on = 1'b1;
         l_nxt.cm_idx = 4'h0;
      end else if (l_r.cm_on) begin
         mem_we = l_r.mask[l_r.cm_idx]; // R16
         l_nxt.cm_idx = l_r.cm_idx + 4'h1;
         if (cm_last) begin
            l_nxt.cm_on = 1'b0;
            l_nxt.busy = 1'b0; // R6 R17
            l_nxt.mask = 16'h0;
         end
      end

      if (start_ev) begin
         l_nxt.st = tws_pkg::ST_DEV; // R2 R5
         l_nxt.cnt = 4'h0;
         l_nxt.ackph = 1'b0;
         l_nxt.oe = 1'b0;
      end else if (stop_ev) begin
         l_nxt.st = tws_pkg::ST_IDLE; // R3
         l_nxt.oe = 1'b0;
         l_nxt.ackph = 1'b0;
         if (l_r.st == tws_pkg::ST_WDATA && l_r.mask != 16'h0 && !l_r.busy) begin
            l_nxt.busy = 1'b1; // R11 R16
            l_nxt.cpage = l_r.addr[10:4];
            l_nxt.req_t = ~l_r.req_t;
         end
      end else begin
         case (l_r.st)
            tws_pkg::ST_DEV, tws_pkg::ST_WORD, tws_pkg::ST_WDATA: begin
               if (rise_ev && !l_r.ackph && l_r.cnt < tws_pkg::BIT_LAST) begin
                  l_nxt.sh = {l_r.sh[6:0], l_r.sda_s2}; // R1
                  l_nxt.cnt = l_r.cnt + 4'h1;
               end else if (byte_end) begin
                  case (l_r.st)
                     tws_pkg::ST_DEV: begin
                        if (dev_match && !l_r.busy) begin // R7 R12 R17
                           l_nxt.blk = l_r.sh[3:1]; // R8
                           l_nxt.oe = 1'b1; // R10
                           l_nxt.ackph = 1'b1;
                           if (l_r.sh[0]) begin
                              l_nxt.st = tws_pkg::ST_RDATA; // R9 R18
                           end else begin
                              l_nxt.st = tws_pkg::ST_WORD; // R9
                           end
                        end else begin
                           l_nxt.st = tws_pkg::ST_IDLE; // R7
                        end
                     end
                     tws_pkg::ST_WORD: begin
                        l_nxt.addr = {l_r.blk, l_r.sh}; // R26 R20
                        l_nxt.mask = 16'h0;
                        l_nxt.oe = 1'b1; // R4
                        l_nxt.ackph = 1'b1;
                        l_nxt.st = tws_pkg::ST_WDATA;
                     end
                     default: begin
                        if (!l_r.wp_s2) begin
                           pb_we = 1'b1; // R23 R15
                           l_nxt.mask[l_r.addr[3:0]] = 1'b1;
                        end
                        l_nxt.addr[3:0] = l_r.addr[3:0] + 4'h1; // R14
                        l_nxt.oe = 1'b1; // R13
                        l_nxt.ackph = 1'b1;
                     end
                  endcase
               end else if (fall_ev && l_r.ackph) begin
                  l_nxt.oe = 1'b0;
                  l_nxt.ackph = 1'b0;
                  l_nxt.cnt = 4'h0;
               end
            end
            tws_pkg::ST_RDATA: begin
               if (rd_load) begin
                  l_nxt.ackph = 1'b0;
                  l_nxt.sh = mem_rd;
                  l_nxt.oe = ~mem_rd[7];
                  l_nxt.cnt = 4'h1;
                  l_nxt.addr = l_r.addr + 11'h1; // R18 R22
               end else if (fall_ev && l_r.cnt < tws_pkg::BIT_LAST) begin
                  l_nxt.oe = ~l_r.sh[6];
                  l_nxt.sh = {l_r.sh[6:0], 1'b0};
                  l_nxt.cnt = l_r.cnt + 4'h1;
               end else if (fall_ev && l_r.cnt == tws_pkg::BIT_LAST) begin
                  l_nxt.oe = 1'b0;
                  l_nxt.cnt = tws_pkg::ACK_SLOT;
               end else if (rise_ev && l_r.cnt == tws_pkg::ACK_SLOT) begin
                  if (l_r.sda_s2) begin
                     l_nxt.st = tws_pkg::ST_IDLE; // R19 R21
                  end else begin
                     l_nxt.ackph = 1'b1; // R21
                  end
               end
            end
            default: begin
            end
         endcase
      end
      l_nxt.stby = l_nxt.st == tws_pkg::ST_IDLE && !l_nxt.busy; // R6
   end

   always_ff @(posedge clk_link) begin
      if (lrst_b) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   // array and page buffer
   always_ff @(posedge clk_link) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
      if (pb_we) begin
         pbuf[l_r.addr[3:0]] <= l_r.sh; // R15
      end
   end

   // self-timed write cycle on the system clock
   always_comb begin
      s_nxt = s_r;
      s_nxt.rq_s1 = l_r.req_t;
      s_nxt.rq_s2 = s_r.rq_s1;
      s_nxt.rq_p = s_r.rq_s2;
      if (s_r.rq_s2 != s_r.rq_p) begin
         s_nxt.run = 1'b1;
         s_nxt.cnt = 17'h0;
      end else if (s_r.run) begin
         if (s_r.cnt == 17'(WR_CYC - 1)) begin
            s_nxt.run = 1'b0; // R24
            s_nxt.dn_t = ~s_r.dn_t;
         end else begin
            s_nxt.cnt = s_r.cnt + 17'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = l_r.oe;
   assign standby = l_r.stby;
   assign wr_busy = l_r.busy;

   property p_oe_low_clk;
      @(posedge clk_link) disable iff (lrst_b)
         $rose(l_r.oe) |-> !l_r.scl_s2;
   endproperty
   a_oe_low_clk: assert property (p_oe_low_clk) else $error("drive began with clock high"); // R1

   property p_idle_wait;
      @(posedge clk_link) disable iff (lrst_b)
         l_r.st == tws_pkg::ST_IDLE && !start_ev |=> l_r.st == tws_pkg::ST_IDLE && !l_r.oe;
   endproperty
   a_idle_wait: assert property (p_idle_wait) else $error("left idle without start"); // R2

   property p_stop_end;
      @(posedge clk_link) disable iff (lrst_b)
         stop_ev |=> l_r.st == tws_pkg::ST_IDLE ##1 !l_r.oe;
   endproperty
   a_stop_end: assert property (p_stop_end) else $error("stop did not end operation"); // R3

   property p_dev_ack;
      @(posedge clk_link) disable iff (lrst_b)
         dev_end && dev_match && !l_r.busy |=> l_r.oe && l_r.ackph;
   endproperty
   a_dev_ack: assert property (p_dev_ack) else $error("matching address not acknowledged"); // R10

   property p_dev_nak;
      @(posedge clk_link) disable iff (lrst_b)
         dev_end && !dev_match |=> !l_r.oe && l_r.st == tws_pkg::ST_IDLE;
   endproperty
   a_dev_nak: assert property (p_dev_nak) else $error("foreign code answered"); // R7

   property p_busy_nak;
      @(posedge clk_link) disable iff (lrst_b)
         dev_end && l_r.busy |=> !l_r.oe;
   endproperty
   a_busy_nak: assert property (p_busy_nak) else $error("answered while writing"); // R12

   property p_page_step;
      @(posedge clk_link) disable iff (lrst_b)
         wd_end |=> l_r.addr[10:4] == $past(l_r.addr[10:4]) && l_r.addr[3:0] == $past(l_r.addr[3:0]) + 4'h1;
   endproperty
   a_page_step: assert property (p_page_step) else $error("page pointer stepped wrong"); // R14

   property p_rd_step;
      @(posedge clk_link) disable iff (lrst_b)
         rd_load |=> l_r.addr == $past(l_r.addr) + 11'h1;
   endproperty
   a_rd_step: assert property (p_rd_step) else $error("read counter stepped wrong"); // R18

   property p_wp_hold;
      @(posedge clk_link) disable iff (lrst_b)
         wd_end && l_r.wp_s2 |=> l_r.mask == $past(l_r.mask);
   endproperty
   a_wp_hold: assert property (p_wp_hold) else $error("protected write buffered"); // R23

   property p_commit_done;
      @(posedge clk_link) disable iff (lrst_b)
         cm_last |=> !l_r.busy && l_r.mask == 16'h0 && l_r.stby == (l_r.st == tws_pkg::ST_IDLE);
   endproperty
   a_commit_done: assert property (p_commit_done) else $error("busy after commit"); // R16

   property p_rd_nak;
      @(posedge clk_link) disable iff (lrst_b)
         l_r.st == tws_pkg::ST_RDATA && rise_ev && l_r.cnt == tws_pkg::ACK_SLOT && l_r.sda_s2 && !start_ev
            && !stop_ev |=> l_r.st == tws_pkg::ST_IDLE;
   endproperty
   a_rd_nak: assert property (p_rd_nak) else $error("read went on after no acknowledge"); // R21

   property p_word_ack;
      @(posedge clk_link) disable iff (lrst_b)
         byte_end && l_r.st == tws_pkg::ST_WORD |=> l_r.oe && l_r.ackph && l_r.st == tws_pkg::ST_WDATA;
   endproperty
   a_word_ack: assert property (p_word_ack) else $error("word address not acknowledged"); // R4

   property p_data_ack;
      @(posedge clk_link) disable iff (lrst_b)
         wd_end |=> l_r.oe && l_r.ackph && l_r.st == tws_pkg::ST_WDATA;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("write data byte not acknowledged"); // R13

   property p_dir;
      @(posedge clk_link) disable iff (lrst_b)
         dev_end && dev_match && !l_r.busy |=> l_r.st == ($past(l_r.sh[0]) ? tws_pkg::ST_RDATA : tws_pkg::ST_WORD);
   endproperty
   a_dir: assert property (p_dir) else $error("direction bit decoded wrong"); // R9

   property p_rd_wrap;
      @(posedge clk_link) disable iff (lrst_b)
         rd_load && l_r.addr == 11'h7ff |=> l_r.addr == 11'h000;
   endproperty
   a_rd_wrap: assert property (p_rd_wrap) else $error("read counter did not wrap to zero"); // R22

   property p_start_any;
      @(posedge clk_link) disable iff (lrst_b)
         start_ev |=> l_r.st == tws_pkg::ST_DEV && l_r.cnt == 4'h0 && !l_r.oe && !l_r.ackph;
   endproperty
   a_start_any: assert property (p_start_any) else $error("start did not restart the protocol"); // R5

   property p_wr_bound;
      @(posedge clk_sys) disable iff (rst)
         s_r.run |-> s_r.cnt < 17'(WR_CYC);
   endproperty
   a_wr_bound: assert property (p_wr_bound) else $error("write cycle too long"); // R24

endmodule : tws_eeprom

// *** bench/tws_bus_master.sv ***
module tws_bus_master (
   input wire logic clk_sys,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic q();
      repeat (5) @(negedge clk_sys);
   endtask : q

   // data set while scl low, sampled mid high
   task automatic pulse(input logic low, output logic seen);
      sda_low = low;
      q();
      scl = 1'b1;
      q();
      seen = sda;
      q();
      scl = 1'b0;
      q();
   endtask : pulse

   task automatic start();
      sda_low = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask : stop

   // up to nine clocks until the slave lets data go high, then a start once it has
   task automatic recover(output logic freed);
      freed = 1'b0;
      for (int i = 0; i < 9 && !freed; i++) begin
         sda_low = 1'b0;
         q();
         scl = 1'b1;
         q();
         freed = sda;
         if (!freed) begin
            q();
            scl = 1'b0;
            q();
         end
      end
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask : recover

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(~b[i], s);
      pulse(1'b0, s);
      ack = ~s;
   endtask : send_byte

   task automatic recv_byte(output logic [7:0] b, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(1'b0, b[i]);
      pulse(ack, s);
   endtask : recv_byte
endmodule : tws_bus_master

// *** bench/test_two_wire_serial_eeprom_slave.sv ***
module test_two_wire_serial_eeprom_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] CODE = 4'h9; // arbitrary value
   logic clk_sys, clk_link, rst, wp, sda_o, sda_oe, standby, wr_busy, scl, m_low, sda, ack;
   logic [7:0] rd;
   int num_errors, checks_done;

   // open drain wire with pull-up
   assign sda = (sda_oe ? sda_o : 1'b1) & ~m_low;

   tws_eeprom #(.DEV_CODE(CODE), .WR_CYC(200)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .clk_link(clk_link), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp), .standby(standby), .wr_busy(wr_busy)
   );
   tws_bus_master i_master (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(m_low));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #13;
      forever #40 clk_link = ~clk_link;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      if (num_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic dev(input logic [2:0] blk, input logic rw, input logic exp_ack);
      i_master.start();
      i_master.send_byte({CODE, blk, rw}, ack);
      check(ack, exp_ack);
   endtask : dev

   task automatic point(input logic [10:0] a);
      dev(a[10:8], 1'b0, 1'b1);
      i_master.send_byte(a[7:0], ack);
      check(ack, 1'b1);
   endtask : point

   task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic busy);
      point(a);
      i_master.send_byte(d, ack);
      check(ack, 1'b1);
      i_master.stop();
      repeat (10) @(negedge clk_sys);
      check(wr_busy, busy);
      check(standby, !busy);
   endtask : wr

   task automatic wait_done();
      int n;
      n = 0;
      while (wr_busy !== 1'b0 && n < 4000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 4000) begin
         num_errors++;
         stop_test();
      end
      repeat (10) @(negedge clk_sys);
      check(standby, 1'b1);
   endtask : wait_done

   task automatic rd_at(input logic [10:0] a, input logic [7:0] exp);
      point(a);
      dev(a[10:8], 1'b1, 1'b1);
      i_master.recv_byte(rd, 1'b0);
      check(rd, exp);
      i_master.stop();
      repeat (10) @(negedge clk_sys);
      check(standby, 1'b1);
   endtask : rd_at

   task automatic t_byte_write();
      wr(11'h345, 8'ha5, 1'b1);
      dev(3'h3, 1'b0, 1'b0);
      i_master.stop();
      wait_done();
      dev(3'h3, 1'b0, 1'b1);
      i_master.stop();
      rd_at(11'h345, 8'ha5);
   endtask : t_byte_write

   task automatic t_page();
      int e;
      point(11'h11e);
      for (int k = 0; k < 18; k++) begin
         i_master.send_byte(8'h40 + k[7:0], ack);
         check(ack, 1'b1);
      end
      i_master.stop();
      wait_done();
      point(11'h110);
      dev(3'h1, 1'b1, 1'b1);
      for (int s = 0; s < 15; s++) begin
         e = 'h40 + (s + 2) % 16 + (s >= 14 ? 16 : 0);
         i_master.recv_byte(rd, s < 14 ? 1'b1 : 1'b0);
         check(rd, e[7:0]);
      end
      i_master.stop();
      dev(3'h1, 1'b1, 1'b1);
      i_master.recv_byte(rd, 1'b0);
      check(rd, 8'h51);
      i_master.stop();
   endtask : t_page

   task automatic t_wrap();
      wr(11'h7ff, 8'h3c, 1'b1);
      wait_done();
      wr(11'h000, 8'hc3, 1'b1);
      wait_done();
      point(11'h7ff);
      dev(3'h7, 1'b1, 1'b1);
      i_master.recv_byte(rd, 1'b1);
      check(rd, 8'h3c);
      i_master.recv_byte(rd, 1'b0);
      check(rd, 8'hc3);
      i_master.stop();
   endtask : t_wrap

   task automatic t_refuse();
      i_master.start();
      i_master.send_byte({~CODE, 3'h3, 1'b0}, ack);
      check(ack, 1'b0);
      i_master.stop();
      wp = 1'b1;
      wr(11'h345, 8'h5a, 1'b0);
      wp = 1'b0;
      rd_at(11'h345, 8'ha5);
   endtask : t_refuse

   task automatic t_recover();
      logic freed;
      point(11'h110);
      dev(3'h1, 1'b1, 1'b1);
      i_master.pulse(1'b0, rd[7]);
      i_master.pulse(1'b0, rd[6]);
      check(rd[7:6], 2'h1);
      // slave now holds data low on a zero bit; master abandons the read
      i_master.recover(freed);
      check(freed, 1'b1);
      i_master.send_byte({CODE, 3'h1, 1'b1}, ack);
      check(ack, 1'b1);
      i_master.recv_byte(rd, 1'b0);
      check(rd, 8'h43);
      i_master.stop();
   endtask : t_recover

   initial begin
      num_errors = 0;
      checks_done = 0;
      rst = 1'b1;
      wp = 1'b0;
      // long enough for the link side reset too
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      repeat (10) @(negedge clk_sys);
      check(standby, 1'b1);
      check(sda_oe, 1'b0);
      t_byte_write();
      t_page();
      t_wrap();
      t_recover();
      t_refuse();
      stop_test();
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      num_errors++;
      stop_test();
   end
endmodule : test_two_wire_serial_eeprom_slave
